//--- design/evs_chan_sel.sv
// Purpose: One channel's event selector with a registered trigger.
// Assumes: Events arrive as one-cycle pulses on the same clock.
// Notes:   Unconnected codes see a zero in the event vector.

`timescale 1ns/1ns

module evs_chan_sel #(
  parameter int CODE_W    = 6,
  parameter int NUM_CODES = 64
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Selection and events.
  input  wire logic [CODE_W-1:0]    code_i,
  input  wire logic [NUM_CODES-1:0] events_i,
  // Trigger.
  output logic                      trig_o
);

  logic trig_ff;
  logic nxt_trig_ff;

  // Pick the event whose code is loaded; one source pulse gives one trigger pulse.
  always_comb begin
    nxt_trig_ff = events_i[code_i];
  end

  // Register the trigger.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= nxt_trig_ff;
    end
  end

  assign trig_o = trig_ff;

endmodule

//--- design/evs_pkg.sv
// Purpose: Shared constants and types for the DMA event channel selector.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave port.
// Notes:   Every offset, field position and selector reset value is named here, with the first code of each event group.

package evs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel counts and field layout.
  localparam int NUM_CH      = 16;
  localparam int NUM_MAP     = 12;
  localparam int NUM_REGS    = 3;
  localparam int NUM_CHAIN   = 4;
  localparam int CHAIN_FIRST = 8;
  localparam int CODE_W      = 6;
  localparam int NUM_CODES   = 64;
  localparam int FIELD_STEP  = 8;
  localparam int LANES       = 4;

  // Mask of the writable code bits; the two-bit gaps read as zero.
  localparam logic [31:0] FIELD_MASK = 32'h3f3f3f3f;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [31:0] ADDR_SEL_0_TO_3   = 32'h01a0ff00;
  localparam logic [31:0] ADDR_SEL_4_TO_7   = 32'h01a0ff04;
  localparam logic [31:0] ADDR_SEL_12_TO_15 = 32'h01a0ff0c;
  localparam logic [31:0] ADDR_STATUS       = 32'h01a0ff10;

  // Code held by each mappable slot after reset, slot 0 in the low bits.
  localparam logic [NUM_MAP-1:0][CODE_W-1:0] SEL_RESET = {
    6'h0f, 6'h0e, 6'h0d, 6'h0c, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

  ////////////////////////////////////////////////////////////////////////////////
  // Event codes; codes 0x10 to 0x1f and 0x38 to 0x3f connect nothing.
  localparam int CODE_HOST     = 'h00;
  localparam int CODE_TIMER0   = 'h01;
  localparam int CODE_TIMER1   = 'h02;
  localparam int CODE_MEMIF    = 'h03;
  localparam int CODE_PIN4     = 'h04;
  localparam int CODE_PIN0     = 'h08;
  localparam int CODE_BUF0_TX  = 'h0c;
  localparam int CODE_BUF0_RX  = 'h0d;
  localparam int CODE_BUF1_TX  = 'h0e;
  localparam int CODE_BUF1_RX  = 'h0f;
  localparam int CODE_AUDIO0   = 'h20;
  localparam int CODE_AUDIO1   = 'h26;
  localparam int CODE_TWOWIRE  = 'h2c;
  localparam int CODE_PIN8     = 'h30;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Event carriers; each bit is a one-cycle pulse on the peripheral clock.
  typedef struct packed {
    logic receive_event;
    logic receive_odd_event;
    logic receive_even_event;
    logic transmit_event;
    logic transmit_odd_event;
    logic transmit_even_event;
  } evs_audio_t;

  typedef struct packed {
    logic       twowire1_transmit_event;
    logic       twowire1_receive_event;
    logic       twowire0_transmit_event;
    logic       twowire0_receive_event;
    evs_audio_t audio1;
    evs_audio_t audio0;
    logic       buffered_port1_receive_event;
    logic       buffered_port1_transmit_event;
    logic       buffered_port0_receive_event;
    logic       buffered_port0_transmit_event;
    logic [15:0] pin_event;
    logic       memory_interface_event;
    logic       timer_one_event;
    logic       timer_zero_event;
    logic       host_port_event;
  } evs_events_t;

endpackage

//--- design/evs_top.sv
// Purpose: Routes peripheral synchronization events onto twelve of the sixteen DMA channel triggers.
// Assumes: Event sources and chain inputs run on REF_CLK_I; registers are reached over Avalon-MM.
// Notes:   Every request is answered one cycle after it is first seen.

`timescale 1ns/1ns

module evs_top (
  // Clock and reset.
  input  wire logic                 REF_CLK_I,
  input  wire logic                 ARST_N_I,
  // Avalon-MM slave.
  input  wire logic [31:0]          AVS_ADDRESS_I,
  input  wire logic                 AVS_READ_I,
  input  wire logic                 AVS_WRITE_I,
  input  wire logic [31:0]          AVS_WRITEDATA_I,
  input  wire logic [3:0]           AVS_BYTEENABLE_I,
  output logic [31:0]               AVS_READDATA_O,
  output logic                      AVS_WAITREQUEST_O,
  output logic [1:0]                AVS_RESPONSE_O,
  // Event sources and chaining.
  input  wire evs_pkg::evs_events_t EVENTS_I,
  input  wire logic [3:0]           CHAIN_DONE_I,
  // Channel triggers.
  output logic [15:0]               TRIGGER_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [evs_pkg::NUM_MAP-1:0][evs_pkg::CODE_W-1:0] sel_ff;
  logic [evs_pkg::NUM_MAP-1:0][evs_pkg::CODE_W-1:0] nxt_sel_ff;
  logic [31:0]                      rdata_ff;
  logic [31:0]                      nxt_rdata_ff;
  logic                             wait_ff;
  logic                             nxt_wait_ff;
  logic [1:0]                       resp_ff;
  logic [1:0]                       nxt_resp_ff;
  logic [evs_pkg::NUM_CHAIN-1:0]    chain_ff;
  logic [evs_pkg::NUM_CHAIN-1:0]    nxt_chain_ff;
  logic [evs_pkg::NUM_MAP-1:0]      map_trig;
  logic [evs_pkg::NUM_CODES-1:0]    ev_vec;
  logic [evs_pkg::NUM_MAP-1:0]      unmapped;
  logic                             req;
  logic                             hit_reg;
  logic                             hit_status;
  int                               reg_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Event vector indexed by code; unlisted codes stay zero.
  always_comb begin
    ev_vec                                = '0;
    ev_vec[evs_pkg::CODE_HOST]            = EVENTS_I.host_port_event;
    ev_vec[evs_pkg::CODE_TIMER0]          = EVENTS_I.timer_zero_event;
    ev_vec[evs_pkg::CODE_TIMER1]          = EVENTS_I.timer_one_event;
    ev_vec[evs_pkg::CODE_MEMIF]           = EVENTS_I.memory_interface_event;
    ev_vec[evs_pkg::CODE_PIN4 +: 4]       = EVENTS_I.pin_event[7:4];
    ev_vec[evs_pkg::CODE_PIN0 +: 4]       = EVENTS_I.pin_event[3:0];
    ev_vec[evs_pkg::CODE_BUF0_TX]         = EVENTS_I.buffered_port0_transmit_event;
    ev_vec[evs_pkg::CODE_BUF0_RX]         = EVENTS_I.buffered_port0_receive_event;
    ev_vec[evs_pkg::CODE_BUF1_TX]         = EVENTS_I.buffered_port1_transmit_event;
    ev_vec[evs_pkg::CODE_BUF1_RX]         = EVENTS_I.buffered_port1_receive_event;
    ev_vec[evs_pkg::CODE_AUDIO0 +: 6]     = EVENTS_I.audio0;
    ev_vec[evs_pkg::CODE_AUDIO1 +: 6]     = EVENTS_I.audio1;
    ev_vec[evs_pkg::CODE_TWOWIRE]         = EVENTS_I.twowire0_receive_event;
    ev_vec[evs_pkg::CODE_TWOWIRE + 1]     = EVENTS_I.twowire0_transmit_event;
    ev_vec[evs_pkg::CODE_TWOWIRE + 2]     = EVENTS_I.twowire1_receive_event;
    ev_vec[evs_pkg::CODE_TWOWIRE + 3]     = EVENTS_I.twowire1_transmit_event;
    ev_vec[evs_pkg::CODE_PIN8 +: 8]       = EVENTS_I.pin_event[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One registered selector per mappable channel; several may share one code.
  for (genvar g = 0; g < evs_pkg::NUM_MAP; g++) begin : g_sel
    evs_chan_sel #(
      .CODE_W    (evs_pkg::CODE_W),
      .NUM_CODES (evs_pkg::NUM_CODES)
    ) u_sel (
      .clk_i    (REF_CLK_I),
      .rst_n_i  (ARST_N_I),
      .code_i   (sel_ff[g]),
      .events_i (ev_vec),
      .trig_o   (map_trig[g])
    );
  end

  // Flag slots whose code sits in a reserved range.
  always_comb begin
    for (int i = 0; i < evs_pkg::NUM_MAP; i++) begin
      unmapped[i] = (sel_ff[i][5:4] == 2'h1) || (sel_ff[i][5:3] == 3'h7);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chain inputs are registered so they line up with the mapped triggers.
  always_comb begin
    nxt_chain_ff = CHAIN_DONE_I;
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= nxt_chain_ff;
    end
  end

  // Trigger word: slots 0-7 on channels 0-7, chaining on 8-11, slots 8-11 on 12-15.
  assign TRIGGER_O = {map_trig[11:8], chain_ff, map_trig[7:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode; the word between the second and third register is unmapped.
  assign req = AVS_READ_I || AVS_WRITE_I;

  always_comb begin
    reg_idx    = 0;
    hit_reg    = 1'b1;
    hit_status = 1'b0;
    case (AVS_ADDRESS_I)
      evs_pkg::ADDR_SEL_0_TO_3: begin
        reg_idx = 0;
      end
      evs_pkg::ADDR_SEL_4_TO_7: begin
        reg_idx = 1;
      end
      evs_pkg::ADDR_SEL_12_TO_15: begin
        reg_idx = 2;
      end
      evs_pkg::ADDR_STATUS: begin
        hit_reg    = 1'b0;
        hit_status = 1'b1;
      end
      default: begin
        hit_reg = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer: waitrequest drops for one cycle after a request is first seen.
  always_comb begin
    nxt_wait_ff  = !(req && wait_ff);
    nxt_rdata_ff = rdata_ff;
    nxt_resp_ff  = resp_ff;
    if (req && wait_ff) begin
      nxt_rdata_ff = '0;
      nxt_resp_ff  = (hit_reg || hit_status) ? evs_pkg::RESP_OKAY : evs_pkg::RESP_DECERR;
      if (AVS_READ_I && hit_reg) begin
        for (int l = 0; l < evs_pkg::LANES; l++) begin
          nxt_rdata_ff[l*evs_pkg::FIELD_STEP +: evs_pkg::CODE_W] = sel_ff[reg_idx*evs_pkg::LANES + l];
        end
        nxt_rdata_ff = nxt_rdata_ff & evs_pkg::FIELD_MASK;
      end else if (AVS_READ_I && hit_status) begin
        nxt_rdata_ff[evs_pkg::NUM_MAP-1:0] = unmapped;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
      resp_ff  <= evs_pkg::RESP_OKAY;
    end else begin
      wait_ff  <= nxt_wait_ff;
      rdata_ff <= nxt_rdata_ff;
      resp_ff  <= nxt_resp_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Selector fields; a write lands at the edge where waitrequest is low.
  always_comb begin
    nxt_sel_ff = sel_ff;
    if (AVS_WRITE_I && !wait_ff && hit_reg) begin
      for (int l = 0; l < evs_pkg::LANES; l++) begin
        if (AVS_BYTEENABLE_I[l]) begin
          // Only the low six bits of each byte lane are kept; bits 7:6 are dropped.
          nxt_sel_ff[reg_idx*evs_pkg::LANES + l] =
            AVS_WRITEDATA_I[l*evs_pkg::FIELD_STEP +: evs_pkg::CODE_W];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sel_ff <= evs_pkg::SEL_RESET;
    end else begin
      sel_ff <= nxt_sel_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus outputs straight from their flip-flops.
  assign AVS_READDATA_O    = rdata_ff;
  assign AVS_WAITREQUEST_O = wait_ff;
  assign AVS_RESPONSE_O    = resp_ff;

endmodule

//--- sim/evs_src_model.sv
// Purpose: Behavioural event sources on the far side of the selector.
// Assumes: The bench raises fire_i for one cycle, right after a clock edge.
// Notes:   Reserved codes raise no event, so the selector must stay quiet.
`timescale 1ns/1ns

module evs_src_model (
  // Request from the bench.
  input  wire logic       fire_i,
  input  wire logic [5:0] code_i,
  // Event bundle into the selector.
  output evs_pkg::evs_events_t events_o
);
  logic [39:0] vec;
  int          c;

  // Raises the one source bit that a code names.
  always_comb begin
    vec = 40'h0;
    c = int'(code_i);
    if (fire_i && c < 4) vec[c] = 1'b1;
    else if (fire_i && c < 8) vec[c+4] = 1'b1;
    else if (fire_i && c < 12) vec[c-4] = 1'b1;
    else if (fire_i && c < 16) vec[c+8] = 1'b1;
    else if (fire_i && c >= 32 && c < 48) vec[c-8] = 1'b1;
    else if (fire_i && c >= 48 && c < 56) vec[c-36] = 1'b1;
    events_o = vec;
  end
endmodule

//--- sim/evs_top_asserts.sv
// Purpose: Bus and trigger timing checks for the event selector.
// Assumes: Sees only the ports of evs_top.
// Notes:   Bound to every evs_top instance.
`timescale 1ns/1ns

module evs_chk (
  // Clock and reset.
  input wire logic                 REF_CLK_I,
  input wire logic                 ARST_N_I,
  // Bus.
  input wire logic [31:0]          AVS_ADDRESS_I,
  input wire logic                 AVS_READ_I,
  input wire logic                 AVS_WRITE_I,
  input wire logic [31:0]          AVS_READDATA_O,
  input wire logic                 AVS_WAITREQUEST_O,
  input wire logic [1:0]           AVS_RESPONSE_O,
  // Events and triggers.
  input wire evs_pkg::evs_events_t EVENTS_I,
  input wire logic [3:0]           CHAIN_DONE_I,
  input wire logic [15:0]          TRIGGER_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Request seen and selector address decode.
  wire logic req = AVS_READ_I | AVS_WRITE_I;
  wire logic sel = AVS_ADDRESS_I inside {evs_pkg::ADDR_SEL_0_TO_3, evs_pkg::ADDR_SEL_4_TO_7,
                                         evs_pkg::ADDR_SEL_12_TO_15};
  wire logic bad = !sel && AVS_ADDRESS_I != evs_pkg::ADDR_STATUS;

  property p_ack_one; req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("request not answered next cycle");
  property p_ack_once; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer longer than one cycle");
  property p_decerr; req && AVS_WAITREQUEST_O && bad |=> AVS_RESPONSE_O == evs_pkg::RESP_DECERR; endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped access not refused");
  property p_okay; req && AVS_WAITREQUEST_O && sel |=> AVS_RESPONSE_O == evs_pkg::RESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("selector access refused");
  property p_gap; AVS_READ_I && AVS_WAITREQUEST_O && sel |=> (AVS_READDATA_O & ~evs_pkg::FIELD_MASK) == 32'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("gap bits read nonzero");
  property p_chain; 1'b1 |=> TRIGGER_O[11:8] == $past(CHAIN_DONE_I); endproperty
  a_chain: assert property (p_chain) else $error("chained trigger wrong");
  property p_quiet; EVENTS_I == '0 |=> (TRIGGER_O & 16'hf0ff) == 16'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("trigger without event");
  property p_hold; AVS_WAITREQUEST_O && $past(AVS_WAITREQUEST_O) |-> $stable(AVS_READDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data changed between answers");
endmodule

bind evs_top evs_chk u_chk (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_RESPONSE_O(AVS_RESPONSE_O), .EVENTS_I(EVENTS_I),
  .CHAIN_DONE_I(CHAIN_DONE_I), .TRIGGER_O(TRIGGER_O));

//--- sim/test_evs_top.sv
// Purpose: Self-checking bench for the event selector.
// Assumes: One bus answer per request, triggers one cycle after the event.
// Notes:   A shadow of all channel codes gives every expected event trigger; the chained trigger check uses a fixed value.
`timescale 1ns/1ns

module test_evs_top;
  logic                 clk, arst_n, av_rd, av_wr, fire, av_wait;
  logic [31:0]          av_addr, av_wdata, av_rdata, rdata;
  logic [3:0]           av_be, chain;
  logic [5:0]           code;
  logic [1:0]           av_resp, resp;
  logic [15:0]          trig;
  evs_pkg::evs_events_t ev;
  logic [5:0]           sh [16];
  int                   n_fail = 0;
  int                   checks = 0;
  int                   cyc = 0;

  evs_top u_dut (.REF_CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd),
    .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wdata), .AVS_BYTEENABLE_I(av_be), .AVS_READDATA_O(av_rdata),
    .AVS_WAITREQUEST_O(av_wait), .AVS_RESPONSE_O(av_resp), .EVENTS_I(ev), .CHAIN_DONE_I(chain),
    .TRIGGER_O(trig));
  evs_src_model u_src (.fire_i(fire), .code_i(code), .events_o(ev));

  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares a seen value with its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    int b;
    @(posedge clk);
    av_rd <= !w;
    av_wr <= w;
    av_addr <= a;
    av_wdata <= d;
    av_be <= be;
    do @(posedge clk); while (av_wait !== 1'b0);
    rdata = av_rdata;
    resp = av_resp;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    b = (a == evs_pkg::ADDR_SEL_0_TO_3) ? 0 : (a == evs_pkg::ADDR_SEL_4_TO_7) ? 4 :
        (a == evs_pkg::ADDR_SEL_12_TO_15) ? 12 : -1;
    for (int l = 0; l < 4; l++)
      if (w && b >= 0 && be[l]) sh[b+l] = d[l*8+:6];
  endtask

  // Reads a selector register and compares it with the shadow codes.
  task automatic rdchk(input logic [31:0] a, input int b);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rdata, {2'h0, sh[b+3], 2'h0, sh[b+2], 2'h0, sh[b+1], 2'h0, sh[b]});
    chk({30'h0, resp}, {30'h0, evs_pkg::RESP_OKAY});
  endtask

  // Reads the status word and compares it with the reserved-code flags of the shadow.
  task automatic stchk();
    logic [31:0] e;
    logic [5:0]  s;
    e = 32'h0;
    for (int i = 0; i < 12; i++) begin
      s = sh[(i < 8) ? i : i + 4];
      e[i] = (s >= 6'h10 && s < 6'h20) || s >= 6'h38;
    end
    bus(1'b0, evs_pkg::ADDR_STATUS, 32'h0, 4'hf);
    chk(rdata, e);
    chk({30'h0, resp}, {30'h0, evs_pkg::RESP_OKAY});
  endtask

  // Fires one event code and checks the trigger pattern in the next cycle.
  task automatic evt(input logic [5:0] c);
    logic [15:0] e;
    e = 16'h0;
    for (int n = 0; n < 16; n++)
      if ((n < 8 || n > 11) && sh[n] == c && (c < 6'h10 || (c >= 6'h20 && c < 6'h38))) e[n] = 1'b1;
    @(posedge clk);
    code <= c;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    #1;
    chk({16'h0, trig}, {16'h0, e});
  endtask

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: defaults, unmapped place, remapping, chaining.
  initial begin
    {arst_n, av_rd, av_wr, fire, av_addr, av_wdata, av_be, chain, code} = '0;
    for (int n = 0; n < 16; n++) sh[n] = 6'(n);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(evs_pkg::ADDR_SEL_0_TO_3, 0);
    rdchk(evs_pkg::ADDR_SEL_4_TO_7, 4);
    rdchk(evs_pkg::ADDR_SEL_12_TO_15, 12);
    bus(1'b1, 32'h01a0ff08, 32'hffffffff, 4'hf);
    chk({30'h0, resp}, {30'h0, evs_pkg::RESP_DECERR});
    bus(1'b0, 32'h01a0ff08, 32'h0, 4'hf);
    chk(rdata, 32'h0);
    chk({30'h0, resp}, {30'h0, evs_pkg::RESP_DECERR});
    // A write to the status word is accepted and changes nothing.
    bus(1'b1, evs_pkg::ADDR_STATUS, 32'hffffffff, 4'hf);
    chk({30'h0, resp}, {30'h0, evs_pkg::RESP_OKAY});
    stchk();
    for (int c = 0; c < 64; c++) evt(6'(c));
    bus(1'b1, evs_pkg::ADDR_SEL_0_TO_3, 32'hffffffff, 4'hf);
    bus(1'b1, evs_pkg::ADDR_SEL_4_TO_7, 32'h37302c20, 4'hf);
    bus(1'b1, evs_pkg::ADDR_SEL_12_TO_15, 32'h01010110, 4'hf);
    bus(1'b1, evs_pkg::ADDR_SEL_12_TO_15, 32'h3f3f2b3f, 4'h2);
    rdchk(evs_pkg::ADDR_SEL_0_TO_3, 0);
    rdchk(evs_pkg::ADDR_SEL_4_TO_7, 4);
    rdchk(evs_pkg::ADDR_SEL_12_TO_15, 12);
    stchk();
    for (int c = 0; c < 64; c++) evt(6'(c));
    // A reset in mid-run brings every field back to its channel number.
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int n = 0; n < 16; n++) sh[n] = 6'(n);
    rdchk(evs_pkg::ADDR_SEL_0_TO_3, 0);
    rdchk(evs_pkg::ADDR_SEL_4_TO_7, 4);
    rdchk(evs_pkg::ADDR_SEL_12_TO_15, 12);
    stchk();
    evt(6'h01);
    @(posedge clk);
    chain <= 4'ha;
    @(posedge clk);
    chain <= 4'h0;
    #1;
    chk({16'h0, trig}, 32'h00000a00);
    end_sim();
  end
endmodule
